/* File: hw/sws_slave.sv */
`timescale 1ns/1ns
`default_nettype none
module sws_slave #(
	parameter int RST_CYCLES = sws_pkg::RST_CYC,
	parameter int WSAMP_STD = sws_pkg::WSAMP_STD_CYC,
	parameter int WSAMP_FAST = sws_pkg::WSAMP_FAST_CYC,
	parameter int RDHOLD_STD = sws_pkg::RDHOLD_STD_CYC,
	parameter int RDHOLD_FAST = sws_pkg::RDHOLD_FAST_CYC,
	parameter int FIFO_DEPTH = sws_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic line_hi,
	input wire logic line_lo,
	output logic line_out,
	output logic line_oe_n,
	input wire logic read_mode,
	input wire logic fast_set,
	input wire logic crc_clear,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic [7:0] crc_value,
	output logic crc_zero,
	output logic fast_speed_flag,
	output logic bus_reset,
	output logic slot_ready
);
	initial begin
		if (RST_CYCLES < 2 || RST_CYCLES >= (1 << sws_pkg::RST_W))
			$error("sws_slave reset count out of range");
		if (WSAMP_STD < 1 || WSAMP_FAST < 1 || RDHOLD_STD < 1 || RDHOLD_FAST < 1)
			$error("sws_slave slot timing must be at least one cycle");
		if (WSAMP_STD >= (1 << sws_pkg::TMR_W) || RDHOLD_STD >= (1 << sws_pkg::TMR_W))
			$error("sws_slave slot timing too wide for timer");
	end

	localparam int TW = sws_pkg::TMR_W;
	localparam int RW = sws_pkg::RST_W;
	localparam logic [TW-1:0] WS_STD = TW'(WSAMP_STD);
	localparam logic [TW-1:0] WS_FAST = TW'(WSAMP_FAST);
	localparam logic [TW-1:0] RH_STD = TW'(RDHOLD_STD);
	localparam logic [TW-1:0] RH_FAST = TW'(RDHOLD_FAST);
	localparam logic [TW-1:0] HO_STD = TW'(sws_pkg::HOLDOFF_STD_CYC);
	localparam logic [TW-1:0] HO_FAST = TW'(sws_pkg::HOLDOFF_FAST_CYC);
	localparam logic [TW-1:0] RC_STD = TW'(sws_pkg::REC_STD_CYC);
	localparam logic [TW-1:0] RC_FAST = TW'(sws_pkg::REC_FAST_CYC);
	localparam logic [TW-1:0] FILT = TW'(sws_pkg::FILT_STD_CYC);
	localparam logic [RW-1:0] RST_LIM = RW'(RST_CYCLES);

	sws_stream_if #(.W(sws_pkg::BYTE_W)) fin ();
	sws_stream_if #(.W(sws_pkg::BYTE_W)) fout ();

	sws_fifo #(.W(sws_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_txq (
		.mclk(mclk),
		.rst_n(rst_n),
		.wr(fin),
		.rd(fout)
	);

	assign fin.valid = tx_valid;
	assign fin.data = tx_data;
	assign tx_ready = fin.ready;
	assign line_out = 1'b0;

	sws_pkg::sws_state_e st_r, st_nxt;
	logic [TW-1:0] tmr_r, tmr_nxt, rec_r, rec_nxt;
	logic [RW-1:0] low_r, low_nxt;
	logic rd_slot_r, rd_slot_nxt, drive_r, drive_nxt;
	logic fast_r, fast_nxt, brst_r, brst_nxt;
	logic [7:0] txsh_r, txsh_nxt, rxsh_r, rxsh_nxt, rxd_r, rxd_nxt, crc_r, crc_nxt;
	logic [3:0] txleft_r, txleft_nxt, rxcnt_r, rxcnt_nxt;
	logic rxv_r, rxv_nxt;
	logic [TW-1:0] ws_lim, rh_lim, ho_lim, rc_lim, end_lim;
	logic start, pop, tx_bit;

	always_comb begin
		ws_lim = fast_r ? WS_FAST : WS_STD;
		rh_lim = fast_r ? RH_FAST : RH_STD;
		ho_lim = fast_r ? HO_FAST : HO_STD;
		rc_lim = fast_r ? RC_FAST : RC_STD;
		end_lim = (ws_lim > rh_lim) ? ws_lim : rh_lim;
	end

	assign fout.ready = pop;

	always_comb begin
		st_nxt = st_r;
		tmr_nxt = tmr_r;
		rec_nxt = (rec_r != '0) ? rec_r - 1'b1 : rec_r;
		low_nxt = line_lo ? ((low_r == RST_LIM) ? low_r : low_r + 1'b1) : '0;
		rd_slot_nxt = rd_slot_r;
		drive_nxt = drive_r;
		fast_nxt = fast_r | fast_set;
		brst_nxt = 1'b0;
		txsh_nxt = txsh_r;
		txleft_nxt = txleft_r;
		rxsh_nxt = rxsh_r;
		rxcnt_nxt = rxcnt_r;
		rxd_nxt = rxd_r;
		rxv_nxt = 1'b0;
		// only the 8-bit identifier code is kept here; the 16-bit data code belongs to the layer above
		crc_nxt = crc_clear ? sws_pkg::CRC_INIT : crc_r;
		start = 1'b0;
		pop = 1'b0;
		tx_bit = 1'b1;
		case (st_r)
			sws_pkg::SWS_IDLE: begin
				if (line_lo) begin
					if (fast_r)
						start = 1'b1;
					else begin
						st_nxt = sws_pkg::SWS_FILT;
						tmr_nxt = '0;
					end
				end
			end
			sws_pkg::SWS_FILT: begin
				if (!line_lo)
					st_nxt = sws_pkg::SWS_IDLE;
				else if (tmr_r >= FILT - 1'b1)
					start = 1'b1;
				else
					tmr_nxt = tmr_r + 1'b1;
			end
			sws_pkg::SWS_SLOT: begin
				tmr_nxt = tmr_r + 1'b1;
				// at or past the limit: a speed change mid-slot must not leave the pulldown on
				if (drive_r && tmr_r >= rh_lim - 1'b1)
					drive_nxt = 1'b0;
				if (!rd_slot_r && tmr_r == ws_lim - 1'b1) begin
					rxsh_nxt = {line_hi, rxsh_r[7:1]};
					crc_nxt = sws_pkg::sws_crc_step(crc_nxt, line_hi);
					if (rxcnt_r == 4'h7) begin
						rxcnt_nxt = 4'h0;
						rxd_nxt = {line_hi, rxsh_r[7:1]};
						rxv_nxt = 1'b1;
					end else
						rxcnt_nxt = rxcnt_r + 1'b1;
				end
				if (tmr_r >= end_lim - 1'b1)
					st_nxt = sws_pkg::SWS_WAIT_RISE;
			end
			sws_pkg::SWS_WAIT_RISE: begin
				if (line_hi) begin
					st_nxt = sws_pkg::SWS_HOLDOFF;
					tmr_nxt = '0;
					rec_nxt = rc_lim;
				end
			end
			sws_pkg::SWS_HOLDOFF: begin
				// dips inside the window cannot start a slot; only the bus reset counter (low_r) still counts them
				if (tmr_r >= ho_lim - 1'b1) begin
					if (line_lo)
						start = 1'b1;
					else
						st_nxt = sws_pkg::SWS_IDLE;
				end else
					tmr_nxt = tmr_r + 1'b1;
			end
			default: st_nxt = sws_pkg::SWS_IDLE;
		endcase
		if (start) begin
			st_nxt = sws_pkg::SWS_SLOT;
			tmr_nxt = '0;
			rd_slot_nxt = read_mode;
			drive_nxt = 1'b0;
			if (read_mode) begin
				if (txleft_r != 4'h0) begin
					tx_bit = txsh_r[0];
					txsh_nxt = {1'b1, txsh_r[7:1]};
					txleft_nxt = txleft_r - 1'b1;
				end else if (fout.valid) begin
					pop = 1'b1;
					tx_bit = fout.data[0];
					txsh_nxt = {1'b1, fout.data[7:1]};
					txleft_nxt = 4'h7;
				end
				// an empty queue answers ones, which leaves the line alone
				drive_nxt = !tx_bit;
				crc_nxt = sws_pkg::sws_crc_step(crc_nxt, tx_bit);
			end
		end
		if (low_r == RST_LIM - 1'b1 && line_lo) begin
			fast_nxt = 1'b0;
			brst_nxt = 1'b1;
			txleft_nxt = 4'h0;
			rxcnt_nxt = 4'h0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= sws_pkg::SWS_IDLE;
			tmr_r <= '0;
			rec_r <= '0;
			low_r <= '0;
			rd_slot_r <= 1'b0;
			drive_r <= 1'b0;
			fast_r <= 1'b0;
			brst_r <= 1'b0;
			txsh_r <= '0;
			txleft_r <= '0;
			rxsh_r <= '0;
			rxcnt_r <= '0;
			rxd_r <= '0;
			rxv_r <= 1'b0;
			crc_r <= sws_pkg::CRC_INIT;
		end else begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			rec_r <= rec_nxt;
			low_r <= low_nxt;
			rd_slot_r <= rd_slot_nxt;
			drive_r <= drive_nxt;
			fast_r <= fast_nxt;
			brst_r <= brst_nxt;
			txsh_r <= txsh_nxt;
			txleft_r <= txleft_nxt;
			rxsh_r <= rxsh_nxt;
			rxcnt_r <= rxcnt_nxt;
			rxd_r <= rxd_nxt;
			rxv_r <= rxv_nxt;
			crc_r <= crc_nxt;
		end
	end

	assign line_oe_n = !drive_r;
	assign rx_valid = rxv_r;
	assign rx_data = rxd_r;
	assign crc_value = crc_r;
	assign crc_zero = (crc_r == 8'h00);
	assign fast_speed_flag = fast_r;
	assign bus_reset = brst_r;
	assign slot_ready = (rec_r == '0) && (st_r == sws_pkg::SWS_IDLE || st_r == sws_pkg::SWS_HOLDOFF);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	slot_start_a: assert property ((st_r == sws_pkg::SWS_IDLE && line_lo && fast_r) |=>
		st_r == sws_pkg::SWS_SLOT && tmr_r == '0) else $error("slot did not start on low");
	filt_std_a: assert property ((st_r == sws_pkg::SWS_IDLE && line_lo && !fast_r) |=>
		st_r == sws_pkg::SWS_FILT) else $error("standard speed skipped edge filter");
	glitch_drop_a: assert property ((st_r == sws_pkg::SWS_FILT && !line_lo) |=>
		st_r == sws_pkg::SWS_IDLE && !drive_r) else $error("short dip started a slot");
	holdoff_ign_a: assert property ((st_r == sws_pkg::SWS_HOLDOFF && tmr_r < ho_lim - 1'b1) |=>
		st_r == sws_pkg::SWS_HOLDOFF) else $error("dip accepted inside hold-off");
	late_low_a: assert property ((st_r == sws_pkg::SWS_HOLDOFF && tmr_r >= ho_lim - 1'b1 && line_lo) |=>
		st_r == sws_pkg::SWS_SLOT) else $error("low after hold-off not taken as slot");
	drive_zero_a: assert property ((st_r == sws_pkg::SWS_SLOT && rd_slot_r && drive_r && tmr_r == '0) |->
		!line_oe_n[*2]) else $error("read zero pulldown missing");
	drive_rel_a: assert property ((drive_r && tmr_r == rh_lim - 1'b1 && st_r == sws_pkg::SWS_SLOT) |=>
		line_oe_n) else $error("read zero pulldown not released in time");
	no_drive_one_a: assert property ((st_r != sws_pkg::SWS_SLOT) |-> line_oe_n) else $error("line driven outside slot");
	write_samp_a: assert property ((st_r == sws_pkg::SWS_SLOT && !rd_slot_r && tmr_r == ws_lim - 1'b1) |=>
		rxsh_r[7] == $past(line_hi)) else $error("write bit not sampled at fixed point");
	fast_clr_a: assert property (bus_reset |-> !fast_speed_flag && low_r == RST_LIM) else $error("reset pulse kept fast mode");
	rx_lsb_a: assert property (rx_valid |->
		rx_data == {$past(line_hi), $past(rxsh_r[7:1])}) else $error("rx byte order wrong");
	filt_len_a: assert property ((st_r == sws_pkg::SWS_FILT && tmr_r < FILT - 1'b1) |=>
		st_r != sws_pkg::SWS_SLOT) else $error("filtered low started slot early");
	rd_one_a: assert property ((start && read_mode && tx_bit) |=>
		line_oe_n) else $error("read one drove the line");
	fast_hold_a: assert property ((fast_speed_flag && !(low_r == RST_LIM - 1'b1 && line_lo)) |=>
		fast_speed_flag) else $error("fast mode dropped without reset pulse");
	crc_clr_a: assert property ((crc_clear && st_r == sws_pkg::SWS_IDLE && !line_lo) |=>
		crc_value == sws_pkg::CRC_INIT) else $error("crc clear ignored");

	rd_zero_c: cover property (st_r == sws_pkg::SWS_SLOT && rd_slot_r && drive_r);
	wr_byte_c: cover property (rx_valid);
	reset_c: cover property (bus_reset);
	fast_slot_c: cover property (fast_r && st_r == sws_pkg::SWS_SLOT);
	holdoff_dip_c: cover property (st_r == sws_pkg::SWS_HOLDOFF && line_lo);
endmodule
`default_nettype wire

/* File: hw/sws_pkg.sv */
package sws_pkg;
	localparam int CLK_NS = 8;
	localparam int T_WSAMP_STD_NS = 30000;
	localparam int T_WSAMP_FAST_NS = 4000;
	localparam int T_RDHOLD_STD_NS = 30000;
	localparam int T_RDHOLD_FAST_NS = 3000;
	localparam int T_HOLDOFF_STD_NS = 5000;
	localparam int T_HOLDOFF_FAST_NS = 2000;
	localparam int T_REC_STD_NS = 5000;
	localparam int T_REC_FAST_NS = 2000;
	localparam int T_FILT_STD_NS = 80;
	localparam int T_RST_NS = 480000;

	// least times round up, never below one cycle
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int WSAMP_STD_CYC = cyc_up(T_WSAMP_STD_NS);
	localparam int WSAMP_FAST_CYC = cyc_up(T_WSAMP_FAST_NS);
	localparam int RDHOLD_STD_CYC = cyc_up(T_RDHOLD_STD_NS);
	localparam int RDHOLD_FAST_CYC = cyc_up(T_RDHOLD_FAST_NS);
	localparam int HOLDOFF_STD_CYC = cyc_up(T_HOLDOFF_STD_NS);
	localparam int HOLDOFF_FAST_CYC = cyc_up(T_HOLDOFF_FAST_NS);
	localparam int REC_STD_CYC = cyc_up(T_REC_STD_NS);
	localparam int REC_FAST_CYC = cyc_up(T_REC_FAST_NS);
	localparam int FILT_STD_CYC = cyc_up(T_FILT_STD_NS);
	localparam int RST_CYC = cyc_up(T_RST_NS);

	localparam int TMR_W = 16;
	localparam int RST_W = 18;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic [7:0] CRC_POLY_REV = 8'h8c;
	localparam logic [7:0] CRC_INIT = 8'h00;

	typedef enum logic [2:0] {
		SWS_IDLE,
		SWS_FILT,
		SWS_SLOT,
		SWS_WAIT_RISE,
		SWS_HOLDOFF
	} sws_state_e;

	// lsb-first crc step for x^8+x^5+x^4+1
	function automatic logic [7:0] sws_crc_step(input logic [7:0] crc, input logic b);
		logic fb;
		fb = crc[0] ^ b;
		return (crc >> 1) ^ (fb ? CRC_POLY_REV : 8'h00);
	endfunction
endpackage

/* File: hw/sws_stream_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface sws_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: hw/sws_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module sws_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	sws_stream_if.snk wr,
	sws_stream_if.src rd
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("sws_fifo depth must be a power of two of at least 2");
	end

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic full, empty, push, pop;

	assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign empty = (wp_r == rp_r);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data = mem[rp_r[AW-1:0]];
	assign push = wr.valid && !full;
	assign pop = rd.ready && !empty;

	always_comb begin
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (push)
			mem[wp_r[AW-1:0]] <= wr.data;
	end
endmodule
`default_nettype wire

/* File: verif/sws_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sws_master_model #(
	parameter int WS = 20
) (
	input wire logic mclk,
	input wire logic fast,
	input wire logic line_oe_n,
	input wire logic slot_ready,
	output logic line_hi,
	output logic line_lo,
	output logic stall
);
	logic m_low = 1'b0;
	logic m_shallow = 1'b0;
	// pull-up wins whenever nobody pulls low and no shallow dip (m_shallow) is held
	wire lvl_low = m_low | (line_oe_n === 1'b0);
	assign line_lo = lvl_low;
	assign line_hi = ~lvl_low & ~m_shallow;
	initial stall = 1'b0;
	task automatic pulse(input int n);
		@(negedge mclk) m_low = 1'b1;
		repeat (n) @(negedge mclk);
		m_low = 1'b0;
	endtask
	task automatic gap(input int g);
		int n;
		n = 0;
		repeat (WS + 8) @(negedge mclk);
		if (g == 1) pulse(3);
		repeat (fast ? sws_pkg::HOLDOFF_FAST_CYC : sws_pkg::HOLDOFF_STD_CYC) @(negedge mclk);
		while (slot_ready !== 1'b1 && n < 3000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 3000) stall = 1'b1;
		if (g == 2) begin
			m_shallow = 1'b1;
			repeat (20) @(negedge mclk);
			m_shallow = 1'b0;
		end
	endtask
	task automatic slot(input logic wb, input logic rd, input int g, output logic got);
		int lo;
		lo = fast ? 3 : 13;
		pulse((rd | wb) ? lo : lo + WS + 4);
		repeat (4) @(negedge mclk);
		got = ~lvl_low;
		gap(g);
	endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic mclk, rst_n, line_hi, line_lo, line_out, line_oe_n, read_mode, fast_set, crc_clear;
	logic tx_valid, tx_ready, rx_valid, crc_zero, fast_speed_flag, bus_reset, slot_ready, stall;
	logic [7:0] tx_data, rx_data, crc_value;
	logic [7:0] id [8];
	logic [7:0] q [$];
	int n_errors = 0;
	int n_checks = 0;
	int n_rst = 0;
	int seed = 75;
	sws_slave #(.RST_CYCLES(200), .WSAMP_STD(20), .WSAMP_FAST(12), .RDHOLD_STD(16), .RDHOLD_FAST(10)) sws_slave_inst (
		.mclk(mclk), .rst_n(rst_n), .line_hi(line_hi), .line_lo(line_lo), .line_out(line_out),
		.line_oe_n(line_oe_n), .read_mode(read_mode), .fast_set(fast_set), .crc_clear(crc_clear),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
		.crc_value(crc_value), .crc_zero(crc_zero), .fast_speed_flag(fast_speed_flag),
		.bus_reset(bus_reset), .slot_ready(slot_ready));
	sws_master_model sws_master_model_inst (.mclk(mclk), .fast(fast_speed_flag),
		.line_oe_n(line_oe_n), .slot_ready(slot_ready), .line_hi(line_hi), .line_lo(line_lo), .stall(stall));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_done();
		if (n_errors == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	function automatic logic [7:0] crc8(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
		return c;
	endfunction
	task automatic wr_byte(input logic [7:0] b, input int g);
		logic x;
		read_mode = 1'b0;
		// the byte arrives inside the last slot, before the slot task returns
		q.push_back(b);
		for (int i = 0; i < 8; i++) sws_master_model_inst.slot(b[i], 1'b0, g, x);
	endtask
	task automatic rd_byte(input logic [7:0] e);
		logic [7:0] v;
		read_mode = 1'b1;
		for (int i = 0; i < 8; i++) sws_master_model_inst.slot(1'b1, 1'b1, 0, v[i]);
		read_mode = 1'b0;
		chk("read byte", e, v);
	endtask
	task automatic strobe(ref logic s);
		@(negedge mclk) s = 1'b1;
		@(negedge mclk) s = 1'b0;
	endtask
	always @(negedge mclk) begin
		if (bus_reset === 1'b1) n_rst++;
		if (rx_valid === 1'b1) begin
			if (q.size() == 0) chk("rx unexpected", 8'h00, 8'h01);
			else chk("rx_data", q.pop_front(), rx_data);
		end
	end
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		#(8 * 100000);
		n_errors++;
		test_done();
	end
	initial begin
		{rst_n, read_mode, fast_set, crc_clear, tx_valid} = '0;
		tx_data = 8'($random(seed));
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		chk("reset outputs", 8'h0f, {fast_speed_flag, crc_value == 8'h00, slot_ready, tx_ready, line_oe_n});
		sws_master_model_inst.pulse(5);
		sws_master_model_inst.gap(0);
		wr_byte(8'($random(seed)), 0);
		rd_byte(8'hff);
		strobe(fast_set);
		chk("fast flag", 8'h01, fast_speed_flag);
		for (int i = 0; i < 7; i++) id[i] = 8'($random(seed));
		id[7] = crc8({id[6], id[5], id[4], id[3], id[2], id[1], id[0]});
		strobe(crc_clear);
		chk("crc cleared", 8'h00, crc_value);
		for (int i = 0; i < 8; i++) wr_byte(id[i], 0);
		chk("crc zero after write", 8'h01, crc_zero);
		strobe(crc_clear);
		for (int i = 0; i < 8; i++) begin
			@(negedge mclk) tx_valid = 1'b1;
			tx_data = id[i];
			@(negedge mclk) tx_valid = 1'b0;
		end
		chk("tx full", 8'h00, tx_ready);
		for (int i = 0; i < 8; i++) rd_byte(id[i]);
		chk("crc zero after read", 8'h01, crc_zero);
		wr_byte(8'($random(seed)), 1);
		wr_byte(8'($random(seed)), 2);
		sws_master_model_inst.pulse(205);
		sws_master_model_inst.gap(0);
		chk("bus reset pulses", 8'h01, n_rst[7:0]);
		chk("fast cleared", 8'h00, fast_speed_flag);
		wr_byte(8'($random(seed)), 0);
		chk("model stall", 8'h00, stall);
		chk("rx queue empty", 8'h00, 8'(q.size()));
		test_done();
	end
endmodule
`default_nettype wire
